// [rtl/bit_string_pkg.sv]
// Shared opcodes, states and cycle counts of the bit, accumulator and string executor
package bit_string_pkg;

   // ---------------------------------------------------------------
   // Operation codes presented on op_i
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_BIT_MOVE_LOAD, OP_BIT_MOVE_STORE, OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO,
      OP_BRANCH_IF_BIT_ZERO, OP_BRANCH_IF_BIT_ONE, OP_TEST_AND_SET_BRANCH,
      OP_WAIT_BIT_HIGH, OP_WAIT_BIT_LOW, OP_BYTE_SWAP, OP_ACC_HALF_EXCHANGE,
      OP_SIGN_WIDEN_BYTE, OP_SIGN_WIDEN_WORD, OP_ZERO_WIDEN_BYTE, OP_ZERO_WIDEN_WORD,
      OP_BLOCK_COPY, OP_BLOCK_SEARCH, OP_BLOCK_FILL
   } op_t;

   // Bit address forms
   typedef enum logic [1:0] {FORM_DIRECT, FORM_ABS16, FORM_IO} form_t;

   typedef enum logic [2:0] {ST_IDLE, ST_BIT, ST_POLL, ST_STR, ST_TAIL} state_t;

   // ---------------------------------------------------------------
   // Cycle counts
   // ---------------------------------------------------------------
   localparam logic [3:0] CYC_LOAD_MEM = 4'h5;
   localparam logic [3:0] CYC_LOAD_IO = 4'h4;
   localparam logic [3:0] CYC_STORE_MEM = 4'h7;
   localparam logic [3:0] CYC_STORE_IO = 4'h6;
   localparam logic [3:0] CYC_SET_CLR = 4'h7;
   localparam logic [3:0] CYC_BB_MEM_TAKEN = 4'h8;
   localparam logic [3:0] CYC_BB_MEM_NOT = 4'h7;
   localparam logic [3:0] CYC_BB_IO_TAKEN = 4'h7;
   localparam logic [3:0] CYC_BB_IO_NOT = 4'h6;
   localparam logic [3:0] CYC_TSB_TAKEN = 4'hA;
   localparam logic [3:0] CYC_TSB_NOT = 4'h9;
   localparam logic [3:0] CYC_BYTE_SWAP = 4'h3;
   localparam logic [3:0] CYC_HALF_EXCH = 4'h2;
   localparam logic [3:0] CYC_SIGN_BYTE = 4'h1;
   localparam logic [3:0] CYC_SIGN_WORD = 4'h2;
   localparam logic [3:0] CYC_ZERO_WIDEN = 4'h1;
   localparam logic [3:0] CYC_STR_EMPTY = 4'h5;
   localparam logic [3:0] CYC_COPY_ITEM = 4'h8;
   localparam logic [3:0] CYC_COPY_END = 4'h4;
   localparam logic [3:0] CYC_SRCH_ITEM = 4'h7;
   localparam logic [3:0] CYC_SRCH_END = 4'h4;
   localparam logic [3:0] CYC_SRCH_MATCH = 4'h5;
   localparam logic [3:0] CYC_FILL_ITEM = 4'h6;
   localparam logic [3:0] CYC_FILL_END = 4'h6;
   // Cycles the bit-op read phase spends before the tail count starts
   localparam logic [3:0] CYC_BIT_READ = 4'h2;

   // Flag vector positions (N Z V C)
   localparam int FLG_N = 3;
   localparam int FLG_Z = 2;
   localparam int FLG_V = 1;
   localparam int FLG_C = 0;

endpackage

// [rtl/bit_string_exec.sv]
// Executor for bit, accumulator and string instruction groups of a 16-bit core
// ---------------------------------------------------------------
// Behaviour
// - Bit load puts the bit in accumulator bit 0, clears low half, sets N Z
// - Bit store writes accumulator bit 0 into the byte by read-modify-write
// - Bit set forces the bit to one by read-modify-write, flags kept
// - Bit clear forces the bit to zero by read-modify-write, flags kept
// - Branch-if-zero branches when the bit is zero, Z from the bit
// - Branch-if-one branches when the bit is one, Z from the bit
// - Direct or absolute bit branches: 8 cycles taken, 7 not taken
// - I/O bit branches: 7 cycles taken, 6 not taken
// - Test-and-set branches on one, always writes one, 10 or 9 cycles
// - Wait-high polls the I/O bit until one, flags untouched
// - Wait-low keeps reading the I/O bit until it reads zero
// - Byte swap exchanges accumulator bytes in 3 cycles, flags kept
// - Half exchange swaps accumulator halves in 2 cycles, flags kept
// - Sign widening copies the sign and sets N Z; zero widening clears N
// - Upward byte copy moves low-pointer item to high pointer, both increment
// - Downward byte copy is the same with both pointers decrementing
// - Word copy moves 16-bit items up or down, flags kept
// - Search compares items at high pointer with low half, stops on match
// - Search takes 5 for empty, 4+7m on expiry, 7n+5 on match
// - Copy takes 5 for empty count, else 4 plus 8 per item
// - Fill writes the low half at the high pointer, stepping up or down by down_i, 6m+6 cycles, sets N Z
// - Word fill stores 16-bit low half to each successive word
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module bit_string_exec
   import bit_string_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire op_t op_i,
   input wire form_t form_i,
   input wire logic word_i,
   input wire logic down_i,
   input wire logic [15:0] addr_i,
   input wire logic [2:0] bit_pos_i,
   input wire logic acc_wr_i,
   input wire logic [31:0] acc_wdata_i,
   input wire logic cnt_wr_i,
   input wire logic [15:0] cnt_wdata_i,
   input wire logic [15:0] mem_rdata_i,
   output logic mem_rd_o,
   output logic mem_wr_o,
   output logic mem_io_o,
   output logic mem_word_o,
   output logic mem_lock_o,
   output logic [15:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   output logic [31:0] acc_o,
   output logic [15:0] cnt_o,
   output logic [3:0] flags_o,
   output logic busy_o,
   output logic done_o,
   output logic branch_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      state_t st;
      op_t op;
      logic io;
      logic word;
      logic down;
      logic [15:0] addr;
      logic [2:0] bitp;
      logic [31:0] acc;
      logic [15:0] cnt;
      logic [3:0] flg;
      logic [15:0] data;
      logic match;
      logic [3:0] ph;
      logic [3:0] wt;
      logic mem_rd;
      logic mem_wr;
      logic mem_io;
      logic mem_word;
      logic lock;
      logic done;
      logic branch;
      logic busy;
      logic [15:0] maddr;
      logic [15:0] wdata;
   } core_t;

   core_t s_r;
   core_t s_nxt;
   logic take;
   logic bitv;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Pointer step by item size and direction
   function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic word,
                                            input logic down);
      logic [15:0] d;
      d = word ? 16'h0002 : 16'h0001;
      return down ? p - d : p + d;
   endfunction

   // Replace one bit of a byte
   function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] pos,
                                          input logic v);
      logic [7:0] r;
      r = b;
      r[pos] = v;
      return r;
   endfunction

   // Subtraction flags N Z V C of item minus reference
   function automatic logic [3:0] cmp_flags(input logic [15:0] a, input logic [15:0] b,
                                            input logic word);
      logic [16:0] r;
      r = {1'b0, a} - {1'b0, b};
      if (word) begin
         return {r[15], r[15:0] == 16'h0000, (a[15] ^ b[15]) & (a[15] ^ r[15]), r[16]};
      end
      return {r[7], r[7:0] == 8'h00, (a[7] ^ b[7]) & (a[7] ^ r[7]), r[8]};
   endfunction

   // Cycles spent on one string item
   function automatic logic [3:0] item_len(input op_t op);
      case (op)
         OP_BLOCK_COPY: return CYC_COPY_ITEM;
         OP_BLOCK_SEARCH: return CYC_SRCH_ITEM;
         default: return CYC_FILL_ITEM;
      endcase
   endfunction

   function automatic logic is_rmw(input op_t op);
      return op == OP_BIT_MOVE_STORE || op == OP_BIT_FORCE_ONE ||
             op == OP_BIT_FORCE_ZERO || op == OP_TEST_AND_SET_BRANCH;
   endfunction

   assign take = start_i && ce_i && s_r.st == ST_IDLE;
   assign bitv = mem_rdata_i[s_r.bitp];

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   // Memory strobes and the done and branch pulses are single-cycle; lock is cleared unless the take or ST_BIT sets it; everything else holds by default
   always_comb begin
      logic next_item;
      logic taken;
      logic [3:0] f;
      next_item = 1'b0;
      taken = 1'b0;
      f = 4'h0;
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      s_nxt.branch = 1'b0;
      s_nxt.mem_rd = 1'b0;
      s_nxt.mem_wr = 1'b0;
      s_nxt.lock = 1'b0;
      case (s_r.st)
         ST_IDLE: begin
            if (acc_wr_i) begin
               s_nxt.acc = acc_wdata_i;
            end
            if (cnt_wr_i) begin
               s_nxt.cnt = cnt_wdata_i;
            end
            if (take) begin
               s_nxt.busy = 1'b1;
               s_nxt.op = op_i;
               s_nxt.io = form_i == FORM_IO;
               s_nxt.word = word_i;
               s_nxt.down = down_i;
               s_nxt.addr = addr_i;
               s_nxt.bitp = bit_pos_i;
               s_nxt.ph = 4'h0;
               s_nxt.match = 1'b0;
               case (op_i)
                  OP_BYTE_SWAP: begin
                     s_nxt.acc[15:0] = {s_r.acc[7:0], s_r.acc[15:8]};
                     s_nxt.wt = CYC_BYTE_SWAP;
                     s_nxt.st = ST_TAIL;
                  end
                  OP_ACC_HALF_EXCHANGE: begin
                     s_nxt.acc = {s_r.acc[15:0], s_r.acc[31:16]};
                     s_nxt.wt = CYC_HALF_EXCH;
                     s_nxt.st = ST_TAIL;
                  end
                  OP_SIGN_WIDEN_BYTE, OP_SIGN_WIDEN_WORD,
                  OP_ZERO_WIDEN_BYTE, OP_ZERO_WIDEN_WORD: begin
                     // Widening, flags from the widened result
                     if (op_i == OP_SIGN_WIDEN_BYTE) begin
                        s_nxt.acc[15:8] = {8{s_r.acc[7]}};
                        s_nxt.wt = CYC_SIGN_BYTE;
                     end else if (op_i == OP_SIGN_WIDEN_WORD) begin
                        s_nxt.acc[31:16] = {16{s_r.acc[15]}};
                        s_nxt.wt = CYC_SIGN_WORD;
                     end else if (op_i == OP_ZERO_WIDEN_BYTE) begin
                        s_nxt.acc[15:8] = 8'h00;
                        s_nxt.wt = CYC_ZERO_WIDEN;
                     end else begin
                        s_nxt.acc[31:16] = 16'h0000;
                        s_nxt.wt = CYC_ZERO_WIDEN;
                     end
                     if (op_i == OP_SIGN_WIDEN_WORD || op_i == OP_ZERO_WIDEN_WORD) begin
                        s_nxt.flg[FLG_N] = s_nxt.acc[31];
                        s_nxt.flg[FLG_Z] = s_nxt.acc == 32'h0000_0000;
                     end else begin
                        s_nxt.flg[FLG_N] = s_nxt.acc[15];
                        s_nxt.flg[FLG_Z] = s_nxt.acc[15:0] == 16'h0000;
                     end
                     s_nxt.st = ST_TAIL;
                  end
                  OP_BLOCK_COPY, OP_BLOCK_SEARCH, OP_BLOCK_FILL: begin
                     if (op_i == OP_BLOCK_FILL) begin
                        // Fill flags come from the pattern itself
                        s_nxt.flg[FLG_N] = word_i ? s_r.acc[15] : s_r.acc[7];
                        s_nxt.flg[FLG_Z] = word_i ? s_r.acc[15:0] == 16'h0000 :
                                                    s_r.acc[7:0] == 8'h00;
                     end
                     if (s_r.cnt == 16'h0000) begin
                        s_nxt.wt = (op_i == OP_BLOCK_FILL) ? CYC_FILL_END :
                                   CYC_STR_EMPTY;
                        s_nxt.st = ST_TAIL;
                     end else begin
                        next_item = 1'b1;
                        s_nxt.st = ST_STR;
                     end
                  end
                  default: begin
                     // Every bit form starts with a read of the containing byte
                     s_nxt.mem_rd = 1'b1;
                     s_nxt.mem_io = form_i == FORM_IO;
                     s_nxt.mem_word = 1'b0;
                     s_nxt.maddr = addr_i;
                     s_nxt.lock = is_rmw(op_i);
                     s_nxt.st = (op_i == OP_WAIT_BIT_HIGH || op_i == OP_WAIT_BIT_LOW) ?
                                ST_POLL : ST_BIT;
                  end
               endcase
            end
         end
         ST_BIT: begin
            s_nxt.lock = is_rmw(s_r.op);
            if (s_r.ph == 4'h0) begin
               s_nxt.ph = 4'h1;
            end else begin
               s_nxt.st = ST_TAIL;
               s_nxt.wdata = {8'h00, mem_rdata_i[7:0]};
               s_nxt.mem_wr = is_rmw(s_r.op); // Write right after the read
               case (s_r.op)
                  OP_BIT_MOVE_LOAD: begin
                     // Old low half moves up; low half holds only the bit
                     s_nxt.acc = {s_r.acc[15:0], 15'h0000, bitv};
                     s_nxt.flg[FLG_N] = 1'b0;
                     s_nxt.flg[FLG_Z] = ~bitv;
                     s_nxt.wt = (s_r.io ? CYC_LOAD_IO : CYC_LOAD_MEM) - CYC_BIT_READ;
                  end
                  OP_BIT_MOVE_STORE: begin
                     s_nxt.wdata[7:0] = put_bit(mem_rdata_i[7:0], s_r.bitp, s_r.acc[0]);
                     s_nxt.flg[FLG_N] = s_r.acc[7];
                     s_nxt.flg[FLG_Z] = s_r.acc[7:0] == 8'h00;
                     s_nxt.wt = (s_r.io ? CYC_STORE_IO : CYC_STORE_MEM) - CYC_BIT_READ;
                  end
                  OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO: begin
                     s_nxt.wdata[7:0] = put_bit(mem_rdata_i[7:0], s_r.bitp,
                                              s_r.op == OP_BIT_FORCE_ONE);
                     s_nxt.wt = CYC_SET_CLR - CYC_BIT_READ;
                  end
                  OP_TEST_AND_SET_BRANCH: begin
                     s_nxt.wdata[7:0] = put_bit(mem_rdata_i[7:0], s_r.bitp, 1'b1);
                     s_nxt.match = bitv;
                     s_nxt.flg[FLG_Z] = ~bitv;
                     s_nxt.wt = (bitv ? CYC_TSB_TAKEN : CYC_TSB_NOT) - CYC_BIT_READ;
                  end
                  default: begin
                     // Bit-test branches
                     taken = bitv == (s_r.op == OP_BRANCH_IF_BIT_ONE);
                     s_nxt.match = taken;
                     s_nxt.flg[FLG_Z] = ~bitv;
                     if (s_r.io) begin
                        s_nxt.wt = (taken ? CYC_BB_IO_TAKEN : CYC_BB_IO_NOT) -
                                   CYC_BIT_READ;
                     end else begin
                        s_nxt.wt = (taken ? CYC_BB_MEM_TAKEN : CYC_BB_MEM_NOT) -
                                   CYC_BIT_READ;
                     end
                  end
               endcase
            end
         end
         ST_POLL: begin
            // Read, look, read again; flags are never touched here
            if (s_r.ph == 4'h0) begin
               s_nxt.ph = 4'h1;
            end else if (bitv == (s_r.op == OP_WAIT_BIT_HIGH)) begin
               s_nxt.done = 1'b1;
               s_nxt.busy = 1'b0;
               s_nxt.st = ST_IDLE;
            end else begin
               s_nxt.mem_rd = 1'b1;
               s_nxt.ph = 4'h0;
            end
         end
         ST_STR: begin
            s_nxt.ph = s_r.ph + 4'h1;
            if (s_r.ph == 4'h1 && s_r.op == OP_BLOCK_COPY) begin
               // Source item in hand; write it to the upper pointer
               s_nxt.mem_wr = 1'b1;
               s_nxt.maddr = s_r.acc[31:16];
               s_nxt.wdata = s_r.word ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]};
            end
            if (s_r.ph == 4'h1 && s_r.op == OP_BLOCK_SEARCH) begin
               f = cmp_flags(s_r.word ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]},
                             s_r.word ? s_r.acc[15:0] : {8'h00, s_r.acc[7:0]}, s_r.word);
               s_nxt.flg = f;
               s_nxt.match = f[FLG_Z];
            end
            if (s_r.ph == item_len(s_r.op) - 4'h1) begin
               // Item done: advance pointers, count down
               s_nxt.acc[31:16] = step_ptr(s_r.acc[31:16], s_r.word, s_r.down);
               if (s_r.op == OP_BLOCK_COPY) begin
                  s_nxt.acc[15:0] = step_ptr(s_r.acc[15:0], s_r.word, s_r.down);
               end
               s_nxt.cnt = s_r.cnt - 16'h0001;
               if (s_r.op == OP_BLOCK_SEARCH && s_r.match) begin
                  s_nxt.wt = CYC_SRCH_MATCH;
                  s_nxt.st = ST_TAIL;
               end else if (s_r.cnt == 16'h0001) begin
                  s_nxt.wt = (s_r.op == OP_BLOCK_COPY) ? CYC_COPY_END :
                             (s_r.op == OP_BLOCK_SEARCH) ? CYC_SRCH_END :
                             CYC_FILL_END;
                  s_nxt.st = ST_TAIL;
               end else begin
                  next_item = 1'b1;
               end
            end
         end
         ST_TAIL: begin
            if (s_r.wt <= 4'h1) begin
               s_nxt.done = 1'b1;
               s_nxt.branch = s_r.match;
               s_nxt.busy = 1'b0;
               s_nxt.st = ST_IDLE;
            end else begin
               s_nxt.wt = s_r.wt - 4'h1;
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase
      // Start of a string item: first access on the fresh pointers
      if (next_item) begin
         s_nxt.ph = 4'h0;
         s_nxt.match = 1'b0;
         s_nxt.mem_io = 1'b0;
         s_nxt.mem_word = s_nxt.word;
         if (s_nxt.op == OP_BLOCK_FILL) begin
            s_nxt.mem_wr = 1'b1;
            s_nxt.maddr = s_nxt.acc[31:16];
            s_nxt.wdata = s_nxt.word ? s_nxt.acc[15:0] : {8'h00, s_nxt.acc[7:0]};
         end else begin
            s_nxt.mem_rd = 1'b1;
            s_nxt.maddr = (s_nxt.op == OP_BLOCK_COPY) ? s_nxt.acc[15:0] : s_nxt.acc[31:16];
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Clock enable low freezes everything, memory strobes included
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   assign mem_rd_o = s_r.mem_rd;
   assign mem_wr_o = s_r.mem_wr;
   assign mem_io_o = s_r.mem_io;
   assign mem_word_o = s_r.mem_word;
   assign mem_lock_o = s_r.lock;
   assign mem_addr_o = s_r.maddr;
   assign mem_wdata_o = s_r.wdata;
   assign acc_o = s_r.acc;
   assign cnt_o = s_r.cnt;
   assign flags_o = s_r.flg;
   assign busy_o = s_r.busy;
   assign done_o = s_r.done;
   assign branch_o = s_r.branch;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_swap_time: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      take && op_i == OP_BYTE_SWAP |-> !done_o ##4 done_o)
      else $error("byte swap length wrong");
   a_exch_time: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      take && op_i == OP_ACC_HALF_EXCHANGE |-> ##3 done_o &&
      acc_o == {$past(acc_o[15:0], 3), $past(acc_o[31:16], 3)})
      else $error("half exchange wrong");
   a_bb_mem_time: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      take && (op_i == OP_BRANCH_IF_BIT_ZERO || op_i == OP_BRANCH_IF_BIT_ONE) &&
      form_i != FORM_IO |-> ##[8:9] done_o)
      else $error("memory bit branch length wrong");
   a_bb_io_time: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      take && (op_i == OP_BRANCH_IF_BIT_ZERO || op_i == OP_BRANCH_IF_BIT_ONE) &&
      form_i == FORM_IO |-> ##[7:8] done_o)
      else $error("io bit branch length wrong");
   a_tsb_time: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      take && op_i == OP_TEST_AND_SET_BRANCH |-> ##[10:11] done_o)
      else $error("test and set length wrong");
   a_rmw_pair: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      mem_wr_o && mem_lock_o |-> $past(mem_rd_o, 2) && $past(mem_lock_o))
      else $error("read-modify-write split");
   a_set_value: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      mem_wr_o && mem_lock_o && s_r.op == OP_BIT_FORCE_ONE |->
      mem_wdata_o[7:0] == ($past(mem_rdata_i[7:0]) | (8'h01 << s_r.bitp)))
      else $error("bit set value wrong");
   a_clr_value: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      mem_wr_o && mem_lock_o && s_r.op == OP_BIT_FORCE_ZERO |->
      mem_wdata_o[7:0] == ($past(mem_rdata_i[7:0]) & ~(8'h01 << s_r.bitp)))
      else $error("bit clear value wrong");
   a_wait_flags: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      s_r.st == ST_POLL |=> flags_o == $past(flags_o))
      else $error("wait changed flags");
   a_str_empty: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      take && op_i == OP_BLOCK_COPY && cnt_o == 16'h0000 |-> ##6 done_o)
      else $error("empty copy length wrong");
   a_load_value: assert property (@(posedge mclk_i) disable iff (rst_i || !ce_i)
      done_o && s_r.op == OP_BIT_MOVE_LOAD |->
      acc_o[15:1] == 15'h0000 && flags_o[FLG_Z] == ~acc_o[0])
      else $error("bit load result wrong");

endmodule
`default_nettype wire

// [dv/bit_string_mem.sv]
// Memory model on the far side of the executor bus
`timescale 1ns/1ps
`default_nettype none
module bit_string_mem (
   input wire logic mclk_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic word_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o
);
   logic [7:0] cells [0:255];
   logic [7:0] a;
   assign a = addr_i[7:0];
   initial rdata_o = 16'h0000;
   // Data valid one cycle only; inverted on every idle cycle after, so stale bytes return every second cycle
   always @(posedge mclk_i) begin
      rdata_o <= rd_i ? {cells[a + 8'h01], cells[a]} : ~rdata_o;
      if (wr_i) cells[a] <= wdata_i[7:0];
      if (wr_i && word_i) cells[a + 8'h01] <= wdata_i[15:8];
   end
endmodule
`default_nettype wire

// [dv/bit_string_exec_bench.sv]
// Self-checking bench of the bit, accumulator and string executor
`timescale 1ns/1ps
`default_nettype none
module bit_string_exec_bench;
   import bit_string_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic start_i = 1'b0;
   op_t op_i = OP_BYTE_SWAP;
   form_t form_i = FORM_DIRECT;
   logic [15:0] addr_i = 16'h0010;
   logic [2:0] bit_pos_i = 3'h0;
   logic acc_wr_i = 1'b0;
   logic cnt_wr_i = 1'b0;
   logic [31:0] acc_wdata_i = 32'h00000000;
   logic [15:0] cnt_wdata_i = 16'h0000;
   // Item size and direction, moved only around the word-copy scenario
   logic word_i = 1'b0;
   logic down_i = 1'b0;
   logic rd, wr, wd, busy_o, done_o, branch_o;
   logic [15:0] rdata, maddr, wdata, cnt_o;
   logic [31:0] acc_o;
   logic [3:0] flags_o;
   int miscompares = 0;
   int samples_checked = 0;
   int cyc;
   int ticks = 0;
   always #12.5 mclk_i = ~mclk_i;
   bit_string_mem mem (.mclk_i(mclk_i), .rd_i(rd), .wr_i(wr), .word_i(wd), .addr_i(maddr),
      .wdata_i(wdata), .rdata_o(rdata));
   bit_string_exec dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .start_i(start_i),
      .op_i(op_i), .form_i(form_i), .word_i(word_i), .down_i(down_i), .addr_i(addr_i),
      .bit_pos_i(bit_pos_i), .acc_wr_i(acc_wr_i), .acc_wdata_i(acc_wdata_i),
      .cnt_wr_i(cnt_wr_i), .cnt_wdata_i(cnt_wdata_i), .mem_rdata_i(rdata), .mem_rd_o(rd),
      .mem_wr_o(wr), .mem_io_o(), .mem_word_o(wd), .mem_lock_o(), .mem_addr_o(maddr),
      .mem_wdata_o(wdata), .acc_o(acc_o), .cnt_o(cnt_o), .flags_o(flags_o),
      .busy_o(busy_o), .done_o(done_o), .branch_o(branch_o));
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Wide enough for the longest packed comparison, so no field is cut off
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Counts edges from the taking edge to the done pulse
   task automatic run(input op_t op, input form_t f, input logic [2:0] bp);
      @(posedge mclk_i);
      op_i <= op;
      form_i <= f;
      bit_pos_i <= bp;
      start_i <= 1'b1;
      @(posedge mclk_i);
      start_i <= 1'b0;
      cyc = 0;
      do begin
         @(posedge mclk_i);
         #1 cyc++;
      end while (done_o !== 1'b1 && cyc < 200);
   endtask
   task automatic load(input logic [31:0] a, input logic [15:0] c);
      @(posedge mclk_i);
      {acc_wr_i, cnt_wr_i, acc_wdata_i, cnt_wdata_i} <= {2'b11, a, c};
      @(posedge mclk_i);
      {acc_wr_i, cnt_wr_i} <= 2'b00;
   endtask
   task automatic t_bits();
      run(OP_BIT_FORCE_ONE, FORM_DIRECT, 3'h0);
      chk("set", {cyc[7:0], mem.cells[16], flags_o}, {8'h07, 8'h5B, 4'h0});
      run(OP_BIT_FORCE_ZERO, FORM_IO, 3'h6);
      chk("clr", {cyc[7:0], mem.cells[16]}, 16'h071B);
      run(OP_BIT_MOVE_LOAD, FORM_IO, 3'h4);
      chk("ld", {cyc[7:0], acc_o[15:0], flags_o[3:2]}, {8'h04, 16'h0001, 2'b00});
      run(OP_BRANCH_IF_BIT_ZERO, FORM_DIRECT, 3'h2);
      chk("bz", {cyc[7:0], branch_o, flags_o[FLG_Z]}, {8'h08, 2'b11});
      run(OP_BRANCH_IF_BIT_ZERO, FORM_ABS16, 3'h0);
      chk("bzn", {cyc[7:0], branch_o}, {8'h07, 1'b0});
      run(OP_BRANCH_IF_BIT_ONE, FORM_IO, 3'h0);
      chk("bo", {cyc[7:0], branch_o, flags_o[FLG_Z]}, {8'h07, 2'b10});
      run(OP_BRANCH_IF_BIT_ONE, FORM_IO, 3'h2);
      chk("bon", {cyc[7:0], branch_o}, {8'h06, 1'b0});
      run(OP_TEST_AND_SET_BRANCH, FORM_ABS16, 3'h2);
      chk("ts", {cyc[7:0], branch_o, mem.cells[16]}, {8'h09, 1'b0, 8'h1F});
      run(OP_TEST_AND_SET_BRANCH, FORM_ABS16, 3'h2);
      chk("ts1", {cyc[7:0], branch_o}, {8'h0A, 1'b1});
      run(OP_WAIT_BIT_HIGH, FORM_IO, 3'h0);
      chk("wbh", cyc, 2);
      run(OP_WAIT_BIT_LOW, FORM_IO, 3'h5);
      chk("wbl", cyc, 2);
   endtask
   task automatic t_acc();
      load(32'h11223344, 16'h0001);
      run(OP_BYTE_SWAP, FORM_DIRECT, 3'h0);
      chk("swap", {cyc[3:0], acc_o}, {4'h3, 32'h11224433});
      run(OP_ACC_HALF_EXCHANGE, FORM_DIRECT, 3'h0);
      chk("xch", {cyc[3:0], acc_o}, {4'h2, 32'h44331122});
      load(32'h12340080, 16'h0001);
      run(OP_SIGN_WIDEN_BYTE, FORM_DIRECT, 3'h0);
      chk("sxb", {cyc[3:0], acc_o, flags_o[3:2]}, {4'h1, 32'h1234FF80, 2'b10});
      run(OP_ZERO_WIDEN_WORD, FORM_DIRECT, 3'h0);
      chk("zxw", {cyc[3:0], acc_o, flags_o[3:2]}, {4'h1, 32'h0000FF80, 2'b00});
   endtask
   // Copy, empty copy, fill, a search that hits on its first item, then a downward word copy
   task automatic t_str();
      load(32'h00200010, 16'h0001);
      run(OP_BLOCK_COPY, FORM_DIRECT, 3'h0);
      chk("cp", {cyc[7:0], mem.cells[32], acc_o, cnt_o}, {16'h0C1F, 32'h00210011, 16'h0});
      load(32'h00200010, 16'h0000);
      run(OP_BLOCK_COPY, FORM_DIRECT, 3'h0);
      chk("cp0", cyc, 5);
      load(32'h003000A5, 16'h0002);
      run(OP_BLOCK_FILL, FORM_DIRECT, 3'h0);
      chk("fill", {cyc[7:0], mem.cells[49]}, 16'h12A5);
      load(32'h003000A5, 16'h0003);
      run(OP_BLOCK_SEARCH, FORM_DIRECT, 3'h0);
      chk("srch", {cyc[7:0], cnt_o, flags_o[FLG_Z]}, {8'h0C, 16'h0002, 1'b1});
      // Word copy running downward: both pointers drop by two
      load(32'h00400030, 16'h0001);
      {word_i, down_i} <= 2'b11;
      run(OP_BLOCK_COPY, FORM_DIRECT, 3'h0);
      {word_i, down_i} <= 2'b00;
      chk("cpw", {cyc[7:0], mem.cells[65], mem.cells[64], acc_o}, {8'h0C, 16'hA5A5, 32'h003E002E});
   endtask
   // Guard against a hung handshake
   always @(posedge mclk_i) begin
      ticks++;
      if (ticks == 3000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      mem.cells[16] = 8'h5A;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_bits();
      t_acc();
      t_str();
      end_of_test();
   end
endmodule
`default_nettype wire
